// ==== hdl/fre_pkg.sv ====
// Package of constants and types for the flash row erase and write sequencer.
package fre_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [3:0] ADDR_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_UNLOCK    = 4'h1;
   localparam logic [3:0] ADDR_PTR_LOW   = 4'h2;
   localparam logic [3:0] ADDR_PTR_HIGH  = 4'h3;
   localparam logic [3:0] ADDR_PTR_UPPER = 4'h4;
   localparam logic [3:0] ADDR_LATCH     = 4'h5;
   localparam logic [3:0] ADDR_STATUS    = 4'h6;
   localparam logic [3:0] ADDR_TBL_WRITE = 4'h7;
   localparam logic [3:0] ADDR_PROT      = 4'h8;

   // ***************************************************************
   // Control register fields
   // ***************************************************************
   localparam int CTL_WR      = 0;
   localparam int CTL_GATE    = 2;
   localparam int CTL_ERR     = 3;
   localparam int CTL_FREE    = 4;
   localparam int CTL_REG_LO  = 6;
   localparam int CTL_REG_HI  = 7;
   localparam logic [1:0] REGION_FLASH = 2'h2;

   localparam int STS_DONE    = 0;
   localparam int STS_IRQ_EN  = 1;
   localparam int STS_STALL   = 2;

   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   localparam logic [7:0] LATCH_RESET = 8'hff;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_MHZ        = 125;
   localparam int WRITE_TIME_US  = 2000;
   localparam int ERASE_TIME_US  = 2000;
   localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_ERASE,
      OP_WRITE
   } fre_op_e;

   typedef struct packed {
      logic        start;
      logic        erase;
      logic [21:0] addr;
   } fre_cmd_s;

endpackage : fre_pkg

// ==== hdl/fre_timer.sv ====
// Programming timer that measures the length of one long write.
`timescale 1ns/1ns
module fre_timer #(
   parameter int CNT_W = 20
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             nrst_i,
   // Control
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] count_i,
   input  wire logic             abort_i,
   // Status
   output logic                  busy_o,
   output logic                  done_o
);

   logic [CNT_W-1:0] cnt_q;
   logic             busy_q;
   logic             done_q;
   wire              last_w = busy_q && (cnt_q == '0);

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= last_w && !abort_i;
         if (load_i)
         begin
            cnt_q  <= count_i;
            busy_q <= 1'b1;
         end
         else if (abort_i || last_w)
            busy_q <= 1'b0;
         else if (busy_q)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign busy_o = busy_q;
   assign done_o = done_q;

endmodule : fre_timer

// ==== hdl/fre_seq.sv ====
// Self-programming sequencer for row erase and block write of program flash.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module fre_seq #(
   parameter int BLK_BITS   = 6,
   parameter int ROW_BITS   = 6,
   parameter int ADDR_W     = 22,
   parameter int MEM_BYTES  = 22'h20000,
   parameter int WRITE_CNT  = fre_pkg::WRITE_CYCLES,
   parameter int ERASE_CNT  = fre_pkg::ERASE_CYCLES
) (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              nrst_i,
   // Register port
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [7:0]             reg_rdata_o,
   // Events from the core
   input  wire logic              abort_i,
   // Flash array port
   output logic                   flash_erase_o,
   output logic                   flash_prog_o,
   output logic [ADDR_W-1:0]      flash_addr_o,
   output logic [8*(1<<BLK_BITS)-1:0] flash_data_o,
   output logic                   flash_keep_mask_o,
   // Core side
   output logic                   cpu_stall_o,
   output logic                   irq_o
);

   localparam int NBYTES = 1 << BLK_BITS;
   localparam int CNT_W  = 20;

   // Every check below runs on the core clock and sleeps in reset.
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [7:0]        ptr_l_q, ptr_h_q, ptr_u_q;
   logic [7:0]        latch_q;
   logic [1:0]        region_q;
   logic              free_q, gate_q, wr_q, err_q;
   logic              done_q, irq_en_q, irq_q;
   logic [1:0]        unl_q;
   logic [7:0]        prot_q;
   logic [7:0]        hold_q [NBYTES];
   logic [7:0]        rdata_q;
   logic              erase_q, prog_q, stall_q;
   logic [ADDR_W-1:0] faddr_q;
   fre_pkg::fre_op_e  op_q;

   // ***************************************************************
   // Decoding
   // ***************************************************************
   wire [ADDR_W-1:0] ptr_w = {ptr_u_q[5:0], ptr_h_q, ptr_l_q};
   wire wr_ctl_w  = reg_wr_i && reg_addr_i == fre_pkg::ADDR_CONTROL;
   wire wr_unl_w  = reg_wr_i && reg_addr_i == fre_pkg::ADDR_UNLOCK;
   wire wr_tbl_w  = reg_wr_i && reg_addr_i == fre_pkg::ADDR_TBL_WRITE;
   wire set_wr_w  = wr_ctl_w && reg_wdata_i[fre_pkg::CTL_WR] && !wr_q;
   // The start bit is honoured only straight after the two keys.
   wire unlocked_w = (unl_q == 2'd2);
   // Region and gate are judged on the very write that sets start,
   // so one control write can select, enable and start together.
   wire [1:0] region_w =
              reg_wdata_i[fre_pkg::CTL_REG_HI:fre_pkg::CTL_REG_LO];
   wire flash_sel_w = (region_w == fre_pkg::REGION_FLASH);
   wire gate_w    = reg_wdata_i[fre_pkg::CTL_GATE];
   wire valid_w   = (ptr_w < MEM_BYTES[ADDR_W-1:0]);
   // Protected region: the first prot_q*4 kB of flash.
   wire prot_w    = ptr_w[ADDR_W-1:12] < {2'h0, prot_q};
   wire go_w      = set_wr_w && unlocked_w && flash_sel_w && gate_w;
   wire bad_w     = go_w && (prot_w || !valid_w);
   wire launch_w  = go_w && !bad_w;
   wire is_erase_w = reg_wdata_i[fre_pkg::CTL_FREE];
   logic tmr_busy_w, tmr_done_w;
   wire abort_w   = abort_i && tmr_busy_w;

   wire [CNT_W-1:0] load_cnt_w = is_erase_w ?
        CNT_W'(ERASE_CNT) : CNT_W'(WRITE_CNT);

   fre_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .load_i     (launch_w),
      .count_i    (load_cnt_w),
      .abort_i    (abort_w),
      .busy_o     (tmr_busy_w),
      .done_o     (tmr_done_w)
   );

   // ***************************************************************
   // Unlock sequence
   // ***************************************************************
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         unl_q <= 2'd0;
      else if (wr_unl_w && reg_wdata_i == fre_pkg::UNLOCK_KEY1)
         unl_q <= 2'd1;
      else if (wr_unl_w && reg_wdata_i == fre_pkg::UNLOCK_KEY2
               && unl_q == 2'd1)
         unl_q <= 2'd2;
      else if (reg_wr_i || reg_rd_i)
         unl_q <= 2'd0;
   end

   // ***************************************************************
   // Control and status bits
   // ***************************************************************
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         region_q <= 2'h0;
         free_q   <= 1'b0;
         gate_q   <= 1'b0;
         wr_q     <= 1'b0;
         err_q    <= 1'b0;
         done_q   <= 1'b0;
         irq_en_q <= 1'b0;
         irq_q    <= 1'b0;
         op_q     <= fre_pkg::OP_NONE;
      end
      else
      begin
         if (wr_ctl_w && !wr_q)
         begin
            region_q <= region_w;
            free_q   <= reg_wdata_i[fre_pkg::CTL_FREE];
            gate_q   <= reg_wdata_i[fre_pkg::CTL_GATE];
         end
         // Start only with a valid launch; otherwise it stays clear.
         if (launch_w)
         begin
            wr_q <= 1'b1;
            op_q <= is_erase_w ? fre_pkg::OP_ERASE : fre_pkg::OP_WRITE;
         end
         else if (tmr_done_w || abort_w)
         begin
            wr_q <= 1'b0;
            op_q <= fre_pkg::OP_NONE;
         end
         // Hardware set wins over a software clear.
         if (bad_w || abort_w)
            err_q <= 1'b1;
         else if (wr_ctl_w && !reg_wdata_i[fre_pkg::CTL_ERR])
            err_q <= 1'b0;
         if (tmr_done_w)
            done_q <= 1'b1;
         else if (reg_wr_i && reg_addr_i == fre_pkg::ADDR_STATUS
                  && !reg_wdata_i[fre_pkg::STS_DONE])
            done_q <= 1'b0;
         if (reg_wr_i && reg_addr_i == fre_pkg::ADDR_STATUS)
            irq_en_q <= reg_wdata_i[fre_pkg::STS_IRQ_EN];
         irq_q <= (done_q || tmr_done_w) && irq_en_q;
      end
   end

   // ***************************************************************
   // Pointer, latch and protection registers
   // ***************************************************************
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ptr_l_q <= 8'h00;
         ptr_h_q <= 8'h00;
         ptr_u_q <= 8'h00;
         latch_q <= 8'h00;
         prot_q  <= 8'h00;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            fre_pkg::ADDR_PTR_LOW:   ptr_l_q <= reg_wdata_i;
            fre_pkg::ADDR_PTR_HIGH:  ptr_h_q <= reg_wdata_i;
            fre_pkg::ADDR_PTR_UPPER: ptr_u_q <= {2'h0, reg_wdata_i[5:0]};
            fre_pkg::ADDR_LATCH:     latch_q <= reg_wdata_i;
            fre_pkg::ADDR_PROT:      prot_q  <= reg_wdata_i;
            default:                 ptr_l_q <= ptr_l_q;
         endcase
      end
   end

   // ***************************************************************
   // Holding registers
   // ***************************************************************
   // One latch per block byte; an erase never touches them.
   wire [BLK_BITS-1:0] hidx_w = ptr_l_q[BLK_BITS-1:0];
   wire wr_done_w = tmr_done_w && op_q == fre_pkg::OP_WRITE;

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < NBYTES; i++)
            hold_q[i] <= fre_pkg::LATCH_RESET;
      end
      else if (wr_done_w)
      begin
         for (int i = 0; i < NBYTES; i++)
            hold_q[i] <= fre_pkg::LATCH_RESET;
      end
      else if (wr_tbl_w)
         hold_q[hidx_w] <= latch_q;
   end

   // ***************************************************************
   // Flash array drive and stall
   // ***************************************************************
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         erase_q <= 1'b0;
         prog_q  <= 1'b0;
         stall_q <= 1'b0;
         faddr_q <= '0;
      end
      else
      begin
         stall_q <= launch_w || (tmr_busy_w && !abort_w
                    && !(tmr_done_w));
         if (launch_w && is_erase_w)
            faddr_q <= {ptr_w[ADDR_W-1:ROW_BITS],
                        {ROW_BITS{1'b0}}};
         else if (launch_w)
            faddr_q <= {ptr_w[ADDR_W-1:BLK_BITS],
                        {BLK_BITS{1'b0}}};
         erase_q <= launch_w ? is_erase_w : erase_q && !tmr_done_w
                    && !abort_w;
         prog_q  <= launch_w ? !is_erase_w : prog_q && !tmr_done_w
                    && !abort_w;
      end
   end

   // Array ANDs the latch byte into flash, so FFh leaves it unchanged.
   always_comb
   begin
      for (int i = 0; i < NBYTES; i++)
         flash_data_o[8*i +: 8] = hold_q[i];
   end
   assign flash_keep_mask_o = 1'b1;

   // ***************************************************************
   // Read data
   // ***************************************************************
   wire [7:0] ctl_rd_w = {region_q, 1'b0, free_q, err_q, gate_q,
                          1'b0, wr_q};

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_q <= 8'h00;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            fre_pkg::ADDR_CONTROL:   rdata_q <= ctl_rd_w;
            fre_pkg::ADDR_PTR_LOW:   rdata_q <= ptr_l_q;
            fre_pkg::ADDR_PTR_HIGH:  rdata_q <= ptr_h_q;
            fre_pkg::ADDR_PTR_UPPER: rdata_q <= ptr_u_q;
            fre_pkg::ADDR_LATCH:     rdata_q <= latch_q;
            fre_pkg::ADDR_STATUS:    rdata_q <= {5'h0, stall_q, irq_en_q,
                                                 done_q};
            fre_pkg::ADDR_PROT:      rdata_q <= prot_q;
            default:                 rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   assign reg_rdata_o   = rdata_q;
   assign flash_erase_o = erase_q;
   assign flash_prog_o  = prog_q;
   assign flash_addr_o  = faddr_q;
   assign cpu_stall_o   = stall_q;
   assign irq_o         = irq_q;

   // ***************************************************************
   // Checks
   // ***************************************************************
   bad_start_a: assert property (
      bad_w |=> err_q && !wr_q && !erase_q && !prog_q)
      else $error("bad start not refused");
   no_gate_a: assert property (
      set_wr_w && !gate_w |=> !wr_q)
      else $error("start without gate");
   no_key_a: assert property (
      set_wr_w && !unlocked_w |=> !wr_q)
      else $error("start without unlock");
   region_sel_a: assert property (
      set_wr_w && !flash_sel_w |=> !wr_q)
      else $error("start outside program flash");
   done_flag_a: assert property (
      tmr_done_w |=> done_q && !wr_q)
      else $error("finish not reported");
   done_irq_a: assert property (
      done_q && irq_en_q |=> irq_q)
      else $error("done without interrupt");
   stall_busy_a: assert property (
      launch_w |=> stall_q ##1 stall_q)
      else $error("cpu not stalled");
   erase_row_a: assert property (
      launch_w && is_erase_w |=> faddr_q[ROW_BITS-1:0] == '0)
      else $error("erase row not aligned");
   write_blk_a: assert property (
      launch_w && !is_erase_w |=> faddr_q[BLK_BITS-1:0] == '0)
      else $error("write block not aligned");
   erase_keep_a: assert property (
      tmr_done_w && op_q == fre_pkg::OP_ERASE |=> gate_q == $past(gate_q))
      else $error("erase changed the write gate");
   latch_reset_a: assert property (
      wr_done_w |=> hold_q[0] == 8'hff)
      else $error("latch not reset");
   tbl_load_a: assert property (
      wr_tbl_w && !wr_done_w |=> hold_q[$past(hidx_w)] == $past(latch_q))
      else $error("table write not loaded");
   abort_err_a: assert property (
      abort_w |=> err_q && !wr_q)
      else $error("abort not flagged");
   tbl_done_a: assert property (
      wr_tbl_w && !tmr_done_w |=> done_q == $past(done_q))
      else $error("table write moved done");

endmodule : fre_seq

// ==== bench/fre_seq_tb.sv ====
// Self-checking testbench for the flash row erase and write sequencer.
`timescale 1ns/1ns
module fre_seq_tb;

   // ***************************************************************
   // Signals and design instance
   // ***************************************************************
   // Short programming time so that each long write lasts a few cycles.
   localparam int CNT = 20;

   logic           core_clk_i = 1'b0;
   logic           nrst_i     = 1'b0;
   logic [3:0]     reg_addr_i = 4'h0;
   logic [7:0]     reg_wdata_i = 8'h00;
   logic           reg_wr_i   = 1'b0;
   logic           reg_rd_i   = 1'b0;
   logic           abort_i    = 1'b0;
   logic [7:0]     reg_rdata_o;
   logic           flash_erase_o;
   logic           flash_prog_o;
   logic [21:0]    flash_addr_o;
   logic [511:0]   flash_data_o;
   logic           flash_keep_mask_o;
   logic           cpu_stall_o;
   logic           irq_o;
   int             fail_count = 0;
   int             tests_run  = 0;
   int             cycles     = 0;

   fre_seq #(.WRITE_CNT(CNT), .ERASE_CNT(CNT)) i_dut (
      .core_clk_i        (core_clk_i),
      .nrst_i            (nrst_i),
      .reg_addr_i        (reg_addr_i),
      .reg_wdata_i       (reg_wdata_i),
      .reg_wr_i          (reg_wr_i),
      .reg_rd_i          (reg_rd_i),
      .reg_rdata_o       (reg_rdata_o),
      .abort_i           (abort_i),
      .flash_erase_o     (flash_erase_o),
      .flash_prog_o      (flash_prog_o),
      .flash_addr_o      (flash_addr_o),
      .flash_data_o      (flash_data_o),
      .flash_keep_mask_o (flash_keep_mask_o),
      .cpu_stall_o       (cpu_stall_o),
      .irq_o             (irq_o)
   );

   always #4 core_clk_i = ~core_clk_i;

   // The whole run needs well under a thousand cycles.
   always @(posedge core_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   // ***************************************************************
   // Bus and helper tasks
   // ***************************************************************
   task automatic chk(input logic [511:0] seen, input logic [511:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : chk

   // Each access owns every strobe for its cycle, so no strobe is
   // assigned twice in one time step when accesses follow back to back.
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      reg_wr_i    <= 1'b1;
      reg_rd_i    <= 1'b0;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
   endtask : bus_wr

   task automatic bus_idle();
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : bus_idle

   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      reg_rd_i   <= 1'b1;
      reg_wr_i   <= 1'b0;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask : bus_rd

   task automatic set_ptr(input logic [21:0] p);
      bus_wr(fre_pkg::ADDR_PTR_LOW, p[7:0]);
      bus_wr(fre_pkg::ADDR_PTR_HIGH, p[15:8]);
      bus_wr(fre_pkg::ADDR_PTR_UPPER, {2'h0, p[21:16]});
   endtask : set_ptr

   task automatic tbl_wr(input logic [7:0] d);
      bus_wr(fre_pkg::ADDR_LATCH, d);
      bus_wr(fre_pkg::ADDR_TBL_WRITE, 8'h00);
   endtask : tbl_wr

   task automatic launch(input logic [7:0] k1, k2, ctl);
      bus_wr(fre_pkg::ADDR_UNLOCK, k1);
      bus_wr(fre_pkg::ADDR_UNLOCK, k2);
      bus_wr(fre_pkg::ADDR_CONTROL, ctl);
      bus_idle();
      #1;
   endtask : launch

   task automatic wait_idle(output int n);
      n = 0;
      while (cpu_stall_o !== 1'b0 && n < 100)
      begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
   endtask : wait_idle

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset();
      logic [7:0] d;
      chk({cpu_stall_o, flash_erase_o, flash_prog_o, irq_o}, 4'h0);
      chk(flash_data_o, {512{1'b1}});
      bus_rd(fre_pkg::ADDR_STATUS, d);
      chk(d[0], 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_write();
      logic [511:0] exp;
      logic [7:0]   d;
      int           n;
      exp = {512{1'b1}};
      exp[8*5+:8]  = 8'h3c;
      exp[8*63+:8] = 8'ha5;
      set_ptr(22'h012345);
      tbl_wr(8'h3c);
      set_ptr(22'h01237f);
      tbl_wr(8'ha5);
      bus_rd(fre_pkg::ADDR_STATUS, d);
      chk(d[0], 1'b0);
      chk(flash_data_o, exp);
      bus_wr(fre_pkg::ADDR_STATUS, 8'h02);
      launch(8'h55, 8'haa, 8'h85);
      chk({cpu_stall_o, flash_prog_o, flash_erase_o}, 3'h6);
      chk(flash_addr_o, 22'h012340);
      chk(flash_data_o, exp);
      chk(flash_keep_mask_o, 1'b1);
      wait_idle(n);
      chk(n >= CNT - 2 && n <= CNT + 8, 1'b1);
      chk(flash_data_o, {512{1'b1}});
      bus_rd(fre_pkg::ADDR_CONTROL, d);
      chk(d & 8'hdd, 8'h84);
      bus_rd(fre_pkg::ADDR_STATUS, d);
      chk(d[0], 1'b1);
      chk(irq_o, 1'b1);
      bus_wr(fre_pkg::ADDR_STATUS, 8'h02);
      bus_idle();
      bus_idle();
      #1;
      chk(irq_o, 1'b0);
      $display("test block write done");
   endtask : t_write

   task automatic t_erase();
      logic [511:0] exp;
      logic [7:0]   d;
      int           n;
      exp = {512{1'b1}};
      exp[8*2+:8] = 8'h11;
      set_ptr(22'h000102);
      tbl_wr(8'h11);
      set_ptr(22'h001234);
      launch(8'h55, 8'haa, 8'h95);
      chk({cpu_stall_o, flash_erase_o, flash_prog_o}, 3'h6);
      chk(flash_addr_o, 22'h001200);
      wait_idle(n);
      chk(n >= CNT - 2 && n <= CNT + 8, 1'b1);
      chk(flash_data_o, exp);
      bus_rd(fre_pkg::ADDR_CONTROL, d);
      chk(d & 8'hdd, 8'h94);
      bus_rd(fre_pkg::ADDR_STATUS, d);
      chk(d[0], 1'b1);
      bus_wr(fre_pkg::ADDR_STATUS, 8'h00);
      $display("test row erase done");
   endtask : t_erase

   task automatic t_refuse();
      logic [23:0] cs [5] = '{24'h55aa91, 24'h55aad5, 24'h55aa45,
                              24'haa5595, 24'h555595};
      set_ptr(22'h001240);
      foreach (cs[i])
      begin
         launch(cs[i][23:16], cs[i][15:8], cs[i][7:0]);
         chk({cpu_stall_o, flash_erase_o, flash_prog_o}, 3'h0);
      end
      // A pointer write between the two keys breaks the sequence.
      bus_wr(fre_pkg::ADDR_UNLOCK, 8'h55);
      bus_wr(fre_pkg::ADDR_PTR_LOW, 8'h40);
      bus_wr(fre_pkg::ADDR_UNLOCK, 8'haa);
      bus_wr(fre_pkg::ADDR_CONTROL, 8'h95);
      bus_idle();
      #1;
      chk({cpu_stall_o, flash_erase_o, flash_prog_o}, 3'h0);
      bus_wr(fre_pkg::ADDR_CONTROL, 8'h84);
      $display("test refused starts done");
   endtask : t_refuse

   task automatic t_protect();
      logic [7:0] d;
      bus_wr(fre_pkg::ADDR_PROT, 8'h01);
      set_ptr(22'h000240);
      tbl_wr(8'h77);
      #1;
      chk(flash_data_o[7:0], 8'h77);
      launch(8'h55, 8'haa, 8'h95);
      chk({cpu_stall_o, flash_erase_o}, 2'h0);
      bus_rd(fre_pkg::ADDR_CONTROL, d);
      chk({d[3], d[0]}, 2'h2);
      bus_wr(fre_pkg::ADDR_CONTROL, 8'h84);
      bus_wr(fre_pkg::ADDR_PROT, 8'h00);
      set_ptr(22'h020000);
      launch(8'h55, 8'haa, 8'h85);
      chk({cpu_stall_o, flash_prog_o}, 2'h0);
      bus_rd(fre_pkg::ADDR_CONTROL, d);
      chk({d[3], d[0]}, 2'h2);
      bus_wr(fre_pkg::ADDR_CONTROL, 8'h84);
      $display("test protected and invalid address done");
   endtask : t_protect

   task automatic t_abort();
      logic [7:0] d;
      int         n;
      set_ptr(22'h001240);
      launch(8'h55, 8'haa, 8'h95);
      chk(cpu_stall_o, 1'b1);
      repeat (3) @(posedge core_clk_i);
      abort_i <= 1'b1;
      @(posedge core_clk_i);
      abort_i <= 1'b0;
      wait_idle(n);
      chk(n < 6, 1'b1);
      chk(flash_erase_o, 1'b0);
      bus_rd(fre_pkg::ADDR_CONTROL, d);
      chk(d[3], 1'b1);
      $display("test abort done");
   endtask : t_abort

   // ***************************************************************
   // Main sequence and verdict
   // ***************************************************************
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      t_reset();
      t_write();
      t_erase();
      t_refuse();
      t_protect();
      t_abort();
      end_of_test();
   end

endmodule : fre_seq_tb
